// ==== rtl/reset_cause_pkg.sv ====
package reset_cause_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_PCLOW   = 8'h02;
    localparam logic [7:0] IDX_STATUS  = 8'h03;
    localparam logic [7:0] IDX_INTCTL  = 8'h0B;
    localparam logic [7:0] IDX_PIRQ    = 8'h0C;
    localparam logic [7:0] IDX_WDTCTL  = 8'h18;
    localparam logic [7:0] IDX_OPTION  = 8'h81;
    localparam logic [7:0] IDX_PINDIR  = 8'h85;
    localparam logic [7:0] IDX_PWRCTL  = 8'h8E;
    localparam logic [7:0] IDX_OSCCTL  = 8'h8F;
    localparam logic [7:0] IDX_T2PER   = 8'h92;
    localparam logic [7:0] IDX_CFGLO   = 8'hC0;
    localparam logic [7:0] IDX_CFGHI   = 8'hC1;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ST_TIMEOUT  = 4;
    localparam int ST_SLEEPED  = 3;
    localparam int PC_ULPWAKE  = 5;
    localparam int PC_SWBOR    = 4;
    localparam int PC_PORFLAG  = 1;
    localparam int PC_BORFLAG  = 0;
    localparam int CF_BORMODE  = 8;
    localparam int CF_DMPROT   = 7;
    localparam int CF_CPROT    = 6;
    localparam int CF_PINEN    = 5;
    localparam int CF_PWRTDIS  = 4;
    localparam int CF_WDTEN    = 3;
    localparam int CF_OSCSEL   = 0;
    localparam int IC_GLOBEN   = 7;
    localparam int OC_COND     = 3;

    // ------------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_POR_HI = 8'h18;  // 0001 1xxx, low bits kept
    localparam logic [7:0] PWRCTL_IMPL   = 8'h33;
    localparam logic [7:0] ONES8         = 8'hFF;
    localparam logic [7:0] PINDIR_RST    = 8'h3F;
    localparam logic [7:0] WDTCTL_RST    = 8'h08;
    localparam logic [7:0] WDTCTL_MASK   = 8'h1F;
    localparam logic [7:0] OSCCTL_RST    = 8'h60;
    localparam logic [7:0] OSCCTL_MASK   = 8'h7F;
    localparam logic [7:0] PINDIR_MASK   = 8'h3F;
    localparam logic [7:0] IRQ_VECTOR    = 8'h04;
    localparam logic [9:0] CFG_RST       = 10'h3FF;

    // brown-out modes
    localparam logic [1:0] BOR_OFF  = 2'h0;
    localparam logic [1:0] BOR_SW   = 2'h1;
    localparam logic [1:0] BOR_RUN  = 2'h2;

    typedef enum logic [1:0] {
        PS_RUN   = 2'b01,
        PS_SLEEP = 2'b10
    } pwr_state_t;

    // decoded event of one cycle
    typedef struct packed {
        logic por;
        logic bor;
        logic wdtReset;
        logic wdtWake;
        logic pinRun;
        logic pinSleep;
        logic irqWake;
    } cause_t;

endpackage

// ==== rtl/reset_cause_and_register_init.sv ====
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module reset_cause_and_register_init
    import reset_cause_pkg::*;
(
    input  wire logic        sys_clk,        // 250 MHz core clock
    input  wire logic        srst,           // synchronous reset, high
    input  wire logic        wb_cyc_i,       // wishbone cycle
    input  wire logic        wb_stb_i,       // wishbone strobe
    input  wire logic        wb_we_i,        // wishbone write
    input  wire logic [11:0] wb_adr_i,       // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,       // wishbone byte enables
    input  wire logic [31:0] wb_dat_i,       // wishbone write data
    output logic      [31:0] wb_dat_o,       // wishbone read data
    output logic             wb_ack_o,       // wishbone acknowledge
    input  wire logic        porPulse,       // power-on detector pulse
    input  wire logic        supplyCollapse, // supply fell far, pulse
    input  wire logic        borPulse,       // brown-out detector pulse
    input  wire logic        wdtTimeout,     // watchdog expiry pulse
    input  wire logic        extResetPin_n,  // reset pin, async, low
    input  wire logic        sleepCmd,       // sleep instruction pulse
    input  wire logic [7:0]  wakeIntBits,    // control flags causing wake
    input  wire logic [7:0]  wakePirBits,    // peripheral flags causing wake
    output logic             coreReset,      // one-cycle reset to core
    output logic             sleeping,       // device asleep
    output logic      [7:0]  pcLow           // program counter low byte
);

    // ------------------------------------------------------------------
    // pin synchroniser and edge detect
    // ------------------------------------------------------------------
    logic       pinMeta_q, pinSync_q, pinLast_q;
    logic       pinMeta_d, pinSync_d, pinLast_d;
    logic       pinFall;

    // two stages before anything looks at the pin
    always_comb begin
        pinMeta_d = extResetPin_n;
        pinSync_d = pinMeta_q;
        pinLast_d = pinSync_q;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pinMeta_q <= 1'b1;
            pinSync_q <= 1'b1;
            pinLast_q <= 1'b1;
        end else begin
            pinMeta_q <= pinMeta_d;
            pinSync_q <= pinSync_d;
            pinLast_q <= pinLast_d;
        end
    end

    assign pinFall = pinLast_q & ~pinSync_q;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pwr_state_t  pst_q, pst_d;
    logic [7:0]  status_q, status_d;
    logic [7:0]  pwrCtl_q, pwrCtl_d;
    logic [7:0]  pcLow_q, pcLow_d;
    logic [7:0]  intctl_q, intctl_d;
    logic [7:0]  pirq_q, pirq_d;
    logic [7:0]  wdtctl_q, wdtctl_d;
    logic [7:0]  option_q, option_d;
    logic [7:0]  pindir_q, pindir_d;
    logic [7:0]  oscctl_q, oscctl_d;
    logic [7:0]  t2per_q, t2per_d;
    logic [9:0]  cfg_q, cfg_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic        rst_q, rst_d;
    cause_t      cause;
    logic        asleep, borAllowed, anyReset, anyWake;
    logic        wbReq, wbWr;
    logic [7:0]  idx, wbyte, rbyte;

    assign asleep = (pst_q == PS_SLEEP);

    // ------------------------------------------------------------------
    // cause decode
    // ------------------------------------------------------------------
    // brown-out gating follows the configured mode
    always_comb begin
        case (cfg_q[CF_BORMODE +: 2])
            BOR_OFF: borAllowed = 1'b0;
            BOR_SW:  borAllowed = pwrCtl_q[PC_SWBOR];
            BOR_RUN: borAllowed = ~asleep;
            default: borAllowed = 1'b1;
        endcase
    end

    // strict priority so only one cause is ever recorded per cycle
    always_comb begin
        cause          = '0;
        cause.por      = porPulse | supplyCollapse;
        cause.bor      = ~cause.por & borPulse & borAllowed;
        cause.wdtReset = ~cause.por & ~cause.bor & wdtTimeout
                         & cfg_q[CF_WDTEN] & ~asleep;
        cause.wdtWake  = ~cause.por & ~cause.bor & wdtTimeout
                         & cfg_q[CF_WDTEN] & asleep;
        cause.pinRun   = ~cause.por & ~cause.bor & ~cause.wdtReset & ~cause.wdtWake
                         & pinFall & cfg_q[CF_PINEN] & ~asleep;
        cause.pinSleep = ~cause.por & ~cause.bor & ~cause.wdtWake
                         & pinFall & cfg_q[CF_PINEN] & asleep;
        cause.irqWake  = asleep & ~cause.por & ~cause.bor & ~cause.wdtWake
                         & ~cause.pinSleep & (|{wakeIntBits, wakePirBits});
    end

    assign anyReset = cause.por | cause.bor | cause.wdtReset | cause.pinRun | cause.pinSleep;
    assign anyWake  = cause.wdtWake | cause.irqWake;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign wbReq = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wbWr  = wbReq & wb_we_i & wb_sel_i[0];
    assign idx   = wb_adr_i[9:2];
    assign wbyte = wb_dat_i[7:0];

    // read mux; unmapped and unimplemented bits read zero
    always_comb begin
        case (idx)
            IDX_PCLOW:  rbyte = pcLow_q;
            IDX_STATUS: rbyte = status_q;
            IDX_INTCTL: rbyte = intctl_q;
            IDX_PIRQ:   rbyte = pirq_q;
            IDX_WDTCTL: rbyte = wdtctl_q & WDTCTL_MASK;
            IDX_OPTION: rbyte = option_q;
            IDX_PINDIR: rbyte = pindir_q & PINDIR_MASK;
            IDX_PWRCTL: rbyte = pwrCtl_q & PWRCTL_IMPL;
            IDX_OSCCTL: rbyte = oscctl_q & OSCCTL_MASK;
            IDX_T2PER:  rbyte = t2per_q;
            IDX_CFGLO:  rbyte = cfg_q[7:0];
            IDX_CFGHI:  rbyte = {6'h00, cfg_q[9:8]};
            default:    rbyte = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // next state: software first, hardware events override (set wins)
    // ------------------------------------------------------------------
    always_comb begin
        pst_d    = pst_q;
        status_d = status_q;
        pwrCtl_d = pwrCtl_q;
        pcLow_d  = pcLow_q;
        intctl_d = intctl_q;
        pirq_d   = pirq_q;
        wdtctl_d = wdtctl_q;
        option_d = option_q;
        pindir_d = pindir_q;
        oscctl_d = oscctl_q;
        t2per_d  = t2per_q;
        cfg_d    = cfg_q;
        ack_d    = wbReq;
        rdat_d   = wbReq ? {24'h000000, rbyte} : 32'h00000000;
        rst_d    = anyReset;

        if (wbWr) begin
            case (idx)
                IDX_PCLOW:  pcLow_d = wbyte;
                // flags at 4 and 3 are read only from software
                IDX_STATUS: status_d = {wbyte[7:5], status_q[4:3], wbyte[2:0]};
                IDX_INTCTL: intctl_d = wbyte;
                IDX_PIRQ:   pirq_d = wbyte;
                IDX_WDTCTL: wdtctl_d = wbyte & WDTCTL_MASK;
                IDX_OPTION: option_d = wbyte;
                IDX_PINDIR: pindir_d = wbyte & PINDIR_MASK;
                IDX_PWRCTL: pwrCtl_d = wbyte & PWRCTL_IMPL;
                IDX_OSCCTL: oscctl_d = wbyte & OSCCTL_MASK;
                IDX_T2PER:  t2per_d = wbyte;
                IDX_CFGLO:  cfg_d = {cfg_q[9:8], wbyte};
                IDX_CFGHI:  cfg_d = {wbyte[1:0], cfg_q[7:0]};
                default:    ;
            endcase
        end

        // sleep entry marks time-out set and sleep flag clear
        if (sleepCmd && !asleep && !anyReset) begin
            pst_d                = PS_SLEEP;
            status_d[ST_TIMEOUT] = 1'b1;
            status_d[ST_SLEEPED] = 1'b0;
        end

        if (anyReset) begin
            pst_d    = PS_RUN;
            pcLow_d  = 8'h00;
            intctl_d = 8'h00;
            pirq_d   = 8'h00;
            t2per_d  = ONES8;
            option_d = ONES8;
            pindir_d = PINDIR_RST;
            wdtctl_d = WDTCTL_RST;
            // condition bit left as it was
            oscctl_d = OSCCTL_RST | (oscctl_q & (8'h01 << OC_COND));
            pwrCtl_d[PC_ULPWAKE] = 1'b0;
            status_d[7:5]      = 3'b000;
        end

        // cause flag updates; only one cause is active at a time
        if (cause.por) begin
            status_d           = STATUS_POR_HI | (status_q & 8'h07);
            pwrCtl_d[PC_SWBOR]   = 1'b1;
            pwrCtl_d[PC_PORFLAG] = 1'b0;
        end
        if (cause.bor) begin
            pwrCtl_d[PC_BORFLAG] = 1'b0;
            status_d[ST_TIMEOUT] = 1'b1;
            status_d[ST_SLEEPED] = 1'b1;
        end
        if (cause.wdtReset) begin
            status_d[ST_TIMEOUT] = 1'b0;
        end
        if (cause.pinSleep) begin
            status_d[ST_TIMEOUT] = 1'b1;
            status_d[ST_SLEEPED] = 1'b0;
        end
        // pin reset while running touches no cause flag

        if (anyWake) begin
            pst_d    = PS_RUN;
            t2per_d  = ONES8;
            intctl_d = intctl_d | wakeIntBits;
            pirq_d   = pirq_d | wakePirBits;
            // vector only when global enable already set on waking
            if (cause.irqWake && intctl_q[IC_GLOBEN]) begin
                pcLow_d = IRQ_VECTOR;
            end else begin
                pcLow_d = pcLow_q + 8'h01;
            end
        end
        if (cause.wdtWake) begin
            status_d[ST_TIMEOUT] = 1'b0;
            status_d[ST_SLEEPED] = 1'b0;
        end
        if (cause.irqWake) begin
            status_d[ST_TIMEOUT] = 1'b1;
            status_d[ST_SLEEPED] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // srst stands in for a full power-on with undefined bits as zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pst_q    <= PS_RUN;
            status_q <= STATUS_POR_HI;
            pwrCtl_q <= 8'h01 << PC_SWBOR;
            pcLow_q  <= 8'h00;
            intctl_q <= 8'h00;
            pirq_q   <= 8'h00;
            wdtctl_q <= WDTCTL_RST;
            option_q <= ONES8;
            pindir_q <= PINDIR_RST;
            oscctl_q <= OSCCTL_RST;
            t2per_q  <= ONES8;
            cfg_q    <= CFG_RST;
            ack_q    <= 1'b0;
            rdat_q   <= 32'h00000000;
            rst_q    <= 1'b0;
        end else begin
            pst_q    <= pst_d;
            status_q <= status_d;
            pwrCtl_q <= pwrCtl_d;
            pcLow_q  <= pcLow_d;
            intctl_q <= intctl_d;
            pirq_q   <= pirq_d;
            wdtctl_q <= wdtctl_d;
            option_q <= option_d;
            pindir_q <= pindir_d;
            oscctl_q <= oscctl_d;
            t2per_q  <= t2per_d;
            cfg_q    <= cfg_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
            rst_q    <= rst_d;
        end
    end

    assign wb_ack_o  = ack_q;
    assign wb_dat_o  = rdat_q;
    assign coreReset = rst_q;
    assign sleeping  = pst_q[1];
    assign pcLow     = pcLow_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_porSeen;
        cause.por;
    endsequence

    sequence s_wakeSeen;
        asleep && wdtTimeout && cfg_q[CF_WDTEN] && !porPulse && !supplyCollapse && !borPulse;
    endsequence

    a_por_flags: assert property (@(posedge sys_clk) disable iff (srst)
        s_porSeen |=> !pwrCtl_q[PC_PORFLAG] && status_q[ST_TIMEOUT] && status_q[ST_SLEEPED])
        else $error("power-on flags wrong");

    a_bor_flags: assert property (@(posedge sys_clk) disable iff (srst)
        cause.bor |=> !pwrCtl_q[PC_BORFLAG] && status_q[4:3] == 2'b11
                      && pwrCtl_q[PC_PORFLAG] == $past(pwrCtl_q[PC_PORFLAG]))
        else $error("brown-out flags wrong");

    a_wdt_reset: assert property (@(posedge sys_clk) disable iff (srst)
        cause.wdtReset |=> !status_q[ST_TIMEOUT] && coreReset
                           && status_q[ST_SLEEPED] == $past(status_q[ST_SLEEPED]))
        else $error("watchdog reset flags wrong");

    a_wdt_wake: assert property (@(posedge sys_clk) disable iff (srst)
        s_wakeSeen |=> status_q[4:3] == 2'b00 && !sleeping)
        else $error("watchdog wake flags wrong");

    a_pin_run: assert property (@(posedge sys_clk) disable iff (srst)
        cause.pinRun |=> $stable(status_q[4:3]) && $stable(pwrCtl_q[1:0]))
        else $error("pin reset changed flags");

    a_pin_sleep: assert property (@(posedge sys_clk) disable iff (srst)
        cause.pinSleep |=> status_q[4:3] == 2'b10 && pcLow_q == 8'h00)
        else $error("pin reset in sleep wrong");

    a_reset_init: assert property (@(posedge sys_clk) disable iff (srst)
        anyReset |=> pcLow_q == 8'h00 && intctl_q == 8'h00 && pindir_q == PINDIR_RST
                     && option_q == ONES8 && wdtctl_q == WDTCTL_RST)
        else $error("reset init values wrong");

    a_wake_pc: assert property (@(posedge sys_clk) disable iff (srst)
        cause.irqWake && !intctl_q[IC_GLOBEN] |=> pcLow_q == $past(pcLow_q) + 8'h01)
        else $error("wake pc not advanced");

    a_t2_period: assert property (@(posedge sys_clk) disable iff (srst)
        anyWake |=> t2per_q == ONES8)
        else $error("period not reloaded");

    a_priority: assert property (@(posedge sys_clk) disable iff (srst)
        porPulse && borPulse |-> !cause.bor ##1 !pwrCtl_q[PC_PORFLAG])
        else $error("priority broken");

endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps

module tb;
    import reset_cause_pkg::*;

    // ----------------------------------------------------------------
    // stimulus and observed signals
    // ----------------------------------------------------------------
    logic        sys_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        wb_ack_o, porPulse, supplyCollapse, borPulse, wdtTimeout;
    logic        extResetPin_n, sleepCmd, coreReset, sleeping;
    logic [7:0]  wakeIntBits, wakePirBits, pcLow;
    int          failures = 0;
    int          num_checks = 0;

    reset_cause_and_register_init dut_u (.*);

    // free-running 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; the wait is bounded by the bench only
    task automatic wbXfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                          output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {2'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (n >= 20) begin
            failures++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        wbXfer(1'b1, idx, wd, rd);
    endtask

    task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] mask,
                         input logic [7:0] exp);
        logic [31:0] rd;
        wbXfer(1'b0, idx, 8'h00, rd);
        chk(what, {24'h0, exp}, rd & {24'hFFFFFF, mask});
    endtask

    // m: por, collapse, bor, watchdog, sleep; ib int wake flags, ib rotated right as pir flags, for one cycle
    task automatic pulse(input logic [4:0] m, input logic [7:0] ib, input logic expRst);
        @(posedge sys_clk);
        {sleepCmd, wdtTimeout, borPulse, supplyCollapse, porPulse} <= m;
        wakeIntBits <= ib;
        wakePirBits <= {ib[0], ib[7:1]};
        @(posedge sys_clk);
        {sleepCmd, wdtTimeout, borPulse, supplyCollapse, porPulse} <= 5'h00;
        wakeIntBits <= 8'h00;
        wakePirBits <= 8'h00;
        #1;
        chk("coreReset", {31'h0, expRst}, {31'h0, coreReset});
    endtask

    // pin held low for 8 cycles, core reset looked for meanwhile
    task automatic pinEvent();
        logic seen;
        seen = 1'b0;
        @(posedge sys_clk);
        extResetPin_n <= 1'b0;
        repeat (8) begin
            @(posedge sys_clk);
            seen = seen | (coreReset === 1'b1);
        end
        extResetPin_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("pin coreReset", 32'h1, {31'h0, seen});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic testResetValues();
        wr(IDX_STATUS, 8'h00);
        wr(8'h50, 8'hAA);
        rdChk("status", IDX_STATUS, 8'hFF, 8'h18);
        rdChk("pwrctl", IDX_PWRCTL, 8'hFF, 8'h10);
        rdChk("wdtctl", IDX_WDTCTL, 8'hFF, WDTCTL_RST);
        rdChk("oscctl", IDX_OSCCTL, 8'hFF, 8'h60);
        rdChk("option", IDX_OPTION, 8'hFF, 8'hFF);
        rdChk("pindir", IDX_PINDIR, 8'hFF, 8'h3F);
        rdChk("t2per", IDX_T2PER, 8'hFF, 8'hFF);
        rdChk("cfglo", IDX_CFGLO, 8'hFF, 8'hFF);
        rdChk("cfghi", IDX_CFGHI, 8'hFF, 8'h03);
        rdChk("unmapped", 8'h50, 8'hFF, 8'h00);
        $display("test reset values done");
    endtask

    task automatic testPowerOnAndBrownout();
        wr(IDX_STATUS, 8'h07);
        wr(IDX_PWRCTL, 8'hFF);
        rdChk("pwrctl bits", IDX_PWRCTL, 8'hFF, 8'h33);
        pulse(5'h01, 8'h00, 1'b1);
        rdChk("pwrctl por", IDX_PWRCTL, 8'hFF, 8'h11);
        rdChk("status por", IDX_STATUS, 8'hFF, 8'h1F);
        wr(IDX_PWRCTL, 8'h33);
        wr(IDX_STATUS, 8'hE7);
        wr(IDX_PCLOW, 8'h55);
        pulse(5'h04, 8'h00, 1'b1);
        rdChk("pwrctl bor", IDX_PWRCTL, 8'hFF, 8'h12);
        rdChk("status bor", IDX_STATUS, 8'hFF, 8'h1F);
        chk("pcLow bor", 32'h0, {24'h0, pcLow});
        wr(IDX_PWRCTL, 8'h33);
        pulse(5'h05, 8'h00, 1'b1);
        rdChk("pwrctl both", IDX_PWRCTL, 8'hFF, 8'h11);
        wr(IDX_PWRCTL, 8'h33);
        pulse(5'h02, 8'h00, 1'b1);
        rdChk("pwrctl collapse", IDX_PWRCTL, 8'hFF, 8'h11);
        $display("test power-on and brown-out done");
    endtask

    task automatic testWatchdog();
        wr(IDX_PWRCTL, 8'h33);
        wr(IDX_OPTION, 8'h00);
        pulse(5'h08, 8'h00, 1'b1);
        rdChk("status wdt", IDX_STATUS, 8'hFF, 8'h0F);
        rdChk("pwrctl wdt", IDX_PWRCTL, 8'hFF, 8'h13);
        rdChk("option wdt", IDX_OPTION, 8'hFF, 8'hFF);
        wr(IDX_PWRCTL, 8'h33);
        wr(IDX_PCLOW, 8'h10);
        pulse(5'h10, 8'h00, 1'b0);
        chk("sleeping", 32'h1, {31'h0, sleeping});
        rdChk("flags sleep", IDX_STATUS, 8'h18, 8'h10);
        pulse(5'h08, 8'h00, 1'b0);
        rdChk("flags wake", IDX_STATUS, 8'h18, 8'h00);
        chk("pcLow wake", 32'h11, {24'h0, pcLow});
        chk("awake", 32'h0, {31'h0, sleeping});
        rdChk("pwrctl wake", IDX_PWRCTL, 8'hFF, 8'h33);
        $display("test watchdog done");
    endtask

    task automatic testPin();
        pinEvent();
        rdChk("flags pin run", IDX_STATUS, 8'h18, 8'h00);
        rdChk("pwrctl pin", IDX_PWRCTL, 8'hFF, 8'h13);
        pulse(5'h10, 8'h00, 1'b0);
        pinEvent();
        rdChk("flags pin sleep", IDX_STATUS, 8'h18, 8'h10);
        chk("pcLow pin", 32'h0, {24'h0, pcLow});
        $display("test reset pin done");
    endtask

    // brown-out gating per configured mode, watchdog gated by its enable
    task automatic testGating();
        wr(IDX_CFGHI, 8'h00);
        wr(IDX_PWRCTL, 8'h33);
        pulse(5'h04, 8'h00, 1'b0);
        rdChk("pwrctl bor off", IDX_PWRCTL, 8'hFF, 8'h33);
        wr(IDX_CFGHI, 8'h01);
        pulse(5'h04, 8'h00, 1'b1);
        rdChk("pwrctl bor soft", IDX_PWRCTL, 8'hFF, 8'h12);
        wr(IDX_PWRCTL, 8'h03);
        pulse(5'h04, 8'h00, 1'b0);
        rdChk("pwrctl soft off", IDX_PWRCTL, 8'hFF, 8'h03);
        wr(IDX_CFGHI, 8'h02);
        pulse(5'h10, 8'h00, 1'b0);
        pulse(5'h04, 8'h00, 1'b0);
        chk("asleep bor", 32'h1, {31'h0, sleeping});
        pulse(5'h08, 8'h00, 1'b0);
        pulse(5'h04, 8'h00, 1'b1);
        wr(IDX_CFGLO, 8'hF7);
        pulse(5'h08, 8'h00, 1'b0);
        rdChk("cfglo", IDX_CFGLO, 8'hFF, 8'hF7);
        wr(IDX_CFGLO, 8'hFF);
        wr(IDX_CFGHI, 8'h03);
        $display("test gating done");
    endtask

    task automatic testIrqWake();
        wr(IDX_INTCTL, 8'h80);
        wr(IDX_PCLOW, 8'h20);
        wr(IDX_T2PER, 8'h12);
        pulse(5'h10, 8'h00, 1'b0);
        pulse(5'h00, 8'h02, 1'b0);
        chk("pcLow vector", 32'h04, {24'h0, pcLow});
        rdChk("intctl wake", IDX_INTCTL, 8'hFF, 8'h82);
        rdChk("pirq wake", IDX_PIRQ, 8'hFF, 8'h01);
        rdChk("t2per wake", IDX_T2PER, 8'hFF, 8'hFF);
        rdChk("flags irq", IDX_STATUS, 8'h18, 8'h10);
        wr(IDX_INTCTL, 8'h00);
        wr(IDX_PCLOW, 8'h30);
        pulse(5'h10, 8'h00, 1'b0);
        pulse(5'h00, 8'h02, 1'b0);
        chk("pcLow next", 32'h31, {24'h0, pcLow});
        pulse(5'h08, 8'h00, 1'b1);
        rdChk("intctl rst", IDX_INTCTL, 8'hFF, 8'h00);
        rdChk("pirq rst", IDX_PIRQ, 8'hFF, 8'h00);
        $display("test interrupt wake done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        srst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        {porPulse, supplyCollapse, borPulse, wdtTimeout, sleepCmd} = 5'h00;
        extResetPin_n = 1'b1;
        wakeIntBits = 8'h00;
        wakePirBits = 8'h00;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        testResetValues();
        testPowerOnAndBrownout();
        testWatchdog();
        testPin();
        testIrqWake();
        testGating();
        results();
    end
endmodule
